// ---- ivfr_top.sv ----
`timescale 1ns/10ps
`default_nettype none
// Functional notes
// - Over-voltage warning limit word at 0x57
// - Under-voltage warning limit word also ratio threshold
// - Ratio regulation only when vendor option enables
// - Under-voltage fault limit word at 0x59
// - Action code 00: fault ignored, keep running
// - Code 01: run for delay, then retry setting
// - Code 10: disable output now, then retry setting
// - Code 11: stay off until fault cleared
// - Retry 000: no restart, off until cleared
// - Retry 1..6: that many restarts, then latch off
// - Restart attempts spaced by delay field units
// - Retry 111: endless until off, bias, shutdown
// - Delay code n gives two-to-n units
// - Delay unit length from register 0xD2
module ivfr_top #(
  parameter logic [6:0] DEV_ADDR = ivfr_pkg::DEV_ADDR_DEF,
  parameter int UNIT_NS = ivfr_pkg::UNIT_BASE_NS
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic sclk,
  input wire logic sclIn,
  input wire logic sdaIn,
  input wire logic ctrlOn,
  input wire logic [15:0] vinSample,
  input wire logic vinValid,
  input wire logic otherFault,
  output logic sdaOut,
  output logic sdaOe,
  output logic outputEnable,
  output logic ratioRegulationMode,
  output logic faultLatched
);
  localparam int UNIT_CYC = (UNIT_NS + ivfr_pkg::MCLK_NS - 1) /
                            ivfr_pkg::MCLK_NS;

  if (UNIT_CYC < 1 || UNIT_CYC > 255) begin : g_bad_unit
    $error("delay unit base must be 1 to 255 clock cycles");
  end

  typedef struct packed {
    logic [2:0] syScl;
    logic [2:0] sySda;
    logic [2:0] syCtrl;
    logic [2:0] syTog;
    logic fScl;
    logic fSda;
    logic fCtrl;
    logic fTog;
    logic linkRun;
    logic startDly;
    logic [2:0] nBytes;
    logic [7:0] cmd;
    logic [7:0] dLo;
    logic [7:0] dHi;
    logic [15:0] ovWarnThr;
    logic [15:0] uvWarnThr;
    logic [15:0] uvFaultThr;
    logic [7:0] action;
    logic [15:0] delayUnit;
    logic [7:0] vendorOpt;
    logic [7:0] operation;
    logic [7:0] status;
    logic [15:0] rdWord;
    logic vinLow;
    logic vinUnder;
    logic runOn;
    logic clearPulse;
    logic ratio;
    logic outEn;
    logic latched;
  } ivfr_top_t;

  ivfr_top_t s, next_s;
  logic linkTog;
  logic [7:0] linkByte;
  logic respEn;
  logic respLatched;
  logic [23:0] unitLen;

  assign unitLen = 24'(({8'h00, s.delayUnit} + 24'h000001) *
                       24'(UNIT_CYC));

  ivfr_link u_link (
    .sclk(sclk),
    .linkRst_n(s.linkRun),
    .rst_n(rst_n),
    .sdaIn(sdaIn),
    .devAddr(DEV_ADDR),
    .rdWord(s.rdWord),
    .sdaOut(sdaOut),
    .sdaOe(sdaOe),
    .byteToggle(linkTog),
    .byteData(linkByte)
  );

  ivfr_responder u_resp (
    .mclk(mclk),
    .rst_n(rst_n),
    .faultNow(s.vinLow),
    .action(s.action),
    .unitLen(unitLen),
    .clearReq(s.clearPulse),
    .offCmd(!s.runOn),
    .otherShutdown(otherFault),
    .outEn(respEn),
    .latched(respLatched)
  );

  always_comb begin
    logic startEv;
    logic stopEv;
    logic togEvt;
    logic nextRun;
    startEv = 1'b0;
    stopEv = 1'b0;
    togEvt = 1'b0;
    nextRun = 1'b0;
    next_s = s;
    next_s.clearPulse = 1'b0;
    // Pins and the link toggle are filtered: second and third stage agree
    next_s.syScl = {s.syScl[1:0], sclIn};
    next_s.sySda = {s.sySda[1:0], sdaIn};
    next_s.syCtrl = {s.syCtrl[1:0], ctrlOn};
    next_s.syTog = {s.syTog[1:0], linkTog};
    if (s.syScl[1] == s.syScl[2]) next_s.fScl = s.syScl[2];
    if (s.sySda[1] == s.sySda[2]) next_s.fSda = s.sySda[2];
    if (s.syCtrl[1] == s.syCtrl[2]) next_s.fCtrl = s.syCtrl[2];
    if (s.syTog[1] == s.syTog[2]) next_s.fTog = s.syTog[2];
    startEv = s.fScl && next_s.fScl && s.fSda && !next_s.fSda;
    stopEv = s.fScl && next_s.fScl && !s.fSda && next_s.fSda;
    togEvt = (next_s.fTog != s.fTog);

    // Link side held in reset outside frames and across a repeated start
    next_s.startDly = startEv;
    next_s.linkRun = !startEv && !stopEv && (s.linkRun || s.startDly);

    if (startEv) begin
      next_s.nBytes = 3'h0;
    end else if (togEvt) begin
      unique case (s.nBytes)
        3'h0: next_s.cmd = linkByte;
        3'h1: next_s.dLo = linkByte;
        3'h2: next_s.dHi = linkByte;
        default: ;
      endcase
      if (s.nBytes != 3'h4) next_s.nBytes = s.nBytes + 3'h1;
    end

    // Writes take effect at the stop condition
    if (stopEv) begin
      if (s.nBytes == 3'h1 && s.cmd == ivfr_pkg::CMD_CLEAR_FAULTS) begin
        next_s.status = 8'h00;
        next_s.clearPulse = 1'b1;
      end
      if (s.nBytes == 3'h3) begin
        unique case (s.cmd)
          ivfr_pkg::CMD_OV_WARN: next_s.ovWarnThr = {s.dHi, s.dLo};
          ivfr_pkg::CMD_UV_WARN: next_s.uvWarnThr = {s.dHi, s.dLo};
          ivfr_pkg::CMD_UV_FAULT: next_s.uvFaultThr = {s.dHi, s.dLo};
          ivfr_pkg::CMD_DELAY_UNIT:
            next_s.delayUnit = {s.dHi, s.dLo};
          default: ;
        endcase
      end
      if (s.nBytes == 3'h2) begin
        unique case (s.cmd)
          ivfr_pkg::CMD_UV_ACTION: next_s.action = s.dLo;
          ivfr_pkg::CMD_VENDOR_OPT: next_s.vendorOpt = s.dLo;
          ivfr_pkg::CMD_OPERATION: next_s.operation = s.dLo;
          ivfr_pkg::CMD_STATUS_INPUT: begin
            next_s.status = s.status & ~s.dLo;
            if (s.dLo[ivfr_pkg::STAT_UV_FAULT]) begin
              next_s.clearPulse = 1'b1;
            end
          end
          default: ;
        endcase
      end
    end

    // Off then on through pin or command clears a latched fault
    nextRun = next_s.operation[ivfr_pkg::OP_ON_BIT] && s.fCtrl;
    next_s.runOn = nextRun;
    if (nextRun && !s.runOn) next_s.clearPulse = 1'b1;

    // Flag set applied after clears so a same-cycle event survives
    if (vinValid) begin
      next_s.vinLow = (vinSample < s.uvFaultThr);
      next_s.vinUnder = (vinSample < s.uvWarnThr);
      if (vinSample > s.ovWarnThr) begin
        next_s.status[ivfr_pkg::STAT_OV_WARN] = 1'b1;
      end
      if (vinSample < s.uvWarnThr) begin
        next_s.status[ivfr_pkg::STAT_UV_WARN] = 1'b1;
      end
      if (vinSample < s.uvFaultThr) begin
        next_s.status[ivfr_pkg::STAT_UV_FAULT] = 1'b1;
      end
    end

    next_s.ratio = s.vendorOpt[ivfr_pkg::OPT_RATIO_EN] && s.vinUnder;

    unique case (s.cmd)
      ivfr_pkg::CMD_OV_WARN: next_s.rdWord = s.ovWarnThr;
      ivfr_pkg::CMD_UV_WARN: next_s.rdWord = s.uvWarnThr;
      ivfr_pkg::CMD_UV_FAULT: next_s.rdWord = s.uvFaultThr;
      ivfr_pkg::CMD_UV_ACTION: next_s.rdWord = {8'h00, s.action};
      ivfr_pkg::CMD_DELAY_UNIT: next_s.rdWord = s.delayUnit;
      ivfr_pkg::CMD_VENDOR_OPT: next_s.rdWord = {8'h00, s.vendorOpt};
      ivfr_pkg::CMD_OPERATION: next_s.rdWord = {8'h00, s.operation};
      ivfr_pkg::CMD_STATUS_INPUT: next_s.rdWord = {8'h00, s.status};
      default: next_s.rdWord = 16'hffff;
    endcase
    // Read word moves only while the link side is held idle
    if (s.linkRun) next_s.rdWord = s.rdWord;

    next_s.outEn = respEn && s.runOn;
    next_s.latched = respLatched;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '{syScl: 3'h7, sySda: 3'h7, fScl: 1'b1, fSda: 1'b1,
             ovWarnThr: ivfr_pkg::RST_OV_WARN,
             uvWarnThr: ivfr_pkg::RST_UV_WARN,
             uvFaultThr: ivfr_pkg::RST_UV_FAULT,
             action: ivfr_pkg::RST_ACTION,
             delayUnit: ivfr_pkg::RST_DELAY_UNIT,
             vendorOpt: ivfr_pkg::RST_VENDOR_OPT,
             operation: ivfr_pkg::RST_OPERATION,
             rdWord: 16'hffff,
             default: '0};
    end else begin
      s <= next_s;
    end
  end

  assign outputEnable = s.outEn;
  assign ratioRegulationMode = s.ratio;
  assign faultLatched = s.latched;

  chk_ov_limit_write:
  assert property (@(posedge mclk) disable iff (!rst_n)
    $rose(s.fSda) && s.fScl && s.nBytes == 3'h3
    && s.cmd == ivfr_pkg::CMD_OV_WARN |=> s.ovWarnThr == {s.dHi, s.dLo})
    else $error("over-voltage limit not stored");
  chk_uv_warn_write:
  assert property (@(posedge mclk) disable iff (!rst_n)
    $rose(s.fSda) && s.fScl && s.nBytes == 3'h3
    && s.cmd == ivfr_pkg::CMD_UV_WARN |=> s.uvWarnThr == {s.dHi, s.dLo})
    else $error("under-voltage warning limit not stored");
  chk_uv_fault_write:
  assert property (@(posedge mclk) disable iff (!rst_n)
    $rose(s.fSda) && s.fScl && s.nBytes == 3'h3
    && s.cmd == ivfr_pkg::CMD_UV_FAULT |=> s.uvFaultThr == {s.dHi, s.dLo})
    else $error("under-voltage fault limit not stored");
  chk_ratio_gate:
  assert property (@(posedge mclk) disable iff (!rst_n)
    !s.vendorOpt[ivfr_pkg::OPT_RATIO_EN] |=> !s.ratio)
    else $error("ratio mode active while disabled");
  chk_uv_flag_set:
  assert property (@(posedge mclk) disable iff (!rst_n)
    vinValid && vinSample < s.uvFaultThr
    |=> s.status[ivfr_pkg::STAT_UV_FAULT] && s.vinLow)
    else $error("under-voltage fault flag not raised");
  chk_ov_flag_set:
  assert property (@(posedge mclk) disable iff (!rst_n)
    vinValid && vinSample > s.ovWarnThr
    |=> s.status[ivfr_pkg::STAT_OV_WARN])
    else $error("over-voltage warning flag not raised");
  chk_unit_length:
  assert property (@(posedge mclk) disable iff (!rst_n)
    unitLen == 24'(({8'h00, s.delayUnit} + 24'h000001) * 24'(UNIT_CYC))
    && unitLen != 24'h000000)
    else $error("delay unit length wrong");
  chk_action_write:
  assert property (@(posedge mclk) disable iff (!rst_n)
    $rose(s.fSda) && s.fScl && s.nBytes == 3'h2
    && s.cmd == ivfr_pkg::CMD_UV_ACTION |=> s.action == s.dLo)
    else $error("fault action byte not stored");
  chk_option_write:
  assert property (@(posedge mclk) disable iff (!rst_n)
    $rose(s.fSda) && s.fScl && s.nBytes == 3'h2
    && s.cmd == ivfr_pkg::CMD_VENDOR_OPT |=> s.vendorOpt == s.dLo)
    else $error("option byte not stored");
  chk_unit_write:
  assert property (@(posedge mclk) disable iff (!rst_n)
    $rose(s.fSda) && s.fScl && s.nBytes == 3'h3
    && s.cmd == ivfr_pkg::CMD_DELAY_UNIT |=> s.delayUnit == {s.dHi, s.dLo})
    else $error("delay unit not stored");
  chk_clear_pulse:
  assert property (@(posedge mclk) disable iff (!rst_n)
    $rose(s.fSda) && s.fScl && s.nBytes == 3'h1
    && s.cmd == ivfr_pkg::CMD_CLEAR_FAULTS |-> s.clearPulse)
    else $error("clear command did not release fault");
  chk_uv_warn_flag:
  assert property (@(posedge mclk) disable iff (!rst_n)
    vinValid && vinSample < s.uvWarnThr
    |=> s.status[ivfr_pkg::STAT_UV_WARN] && s.vinUnder)
    else $error("under-voltage warning flag not raised");
endmodule : ivfr_top
`default_nettype wire

// ---- ivfr_pkg.sv ----
`default_nettype none
package ivfr_pkg;
  // Command codes on the management link
  localparam logic [7:0] CMD_OPERATION = 8'h01;
  localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
  localparam logic [7:0] CMD_OV_WARN = 8'h57;
  localparam logic [7:0] CMD_UV_WARN = 8'h58;
  localparam logic [7:0] CMD_UV_FAULT = 8'h59;
  localparam logic [7:0] CMD_UV_ACTION = 8'h5a;
  localparam logic [7:0] CMD_STATUS_INPUT = 8'h7c;
  localparam logic [7:0] CMD_DELAY_UNIT = 8'hd2;
  localparam logic [7:0] CMD_VENDOR_OPT = 8'he0;
  // Fault action byte layout
  localparam int ACT_RESP_LO = 6;
  localparam int ACT_RETRY_LO = 3;
  localparam int ACT_DELAY_LO = 0;
  localparam logic [1:0] RESP_IGNORE = 2'h0;
  localparam logic [1:0] RESP_DELAY = 2'h1;
  localparam logic [1:0] RESP_RETRY = 2'h2;
  localparam logic [1:0] RESP_LATCH = 2'h3;
  localparam logic [2:0] RETRY_NONE = 3'h0;
  localparam logic [2:0] RETRY_FOREVER = 3'h7;
  // Status and option bits
  localparam int STAT_UV_FAULT = 3;
  localparam int STAT_UV_WARN = 4;
  localparam int STAT_OV_WARN = 5;
  localparam int OPT_RATIO_EN = 0;
  localparam int OP_ON_BIT = 7;
  // Reset values
  localparam logic [15:0] RST_OV_WARN = 16'hffff;
  localparam logic [15:0] RST_UV_WARN = 16'h0000;
  localparam logic [15:0] RST_UV_FAULT = 16'h0000;
  localparam logic [7:0] RST_ACTION = 8'h00;
  localparam logic [15:0] RST_DELAY_UNIT = 16'h0000;
  localparam logic [7:0] RST_VENDOR_OPT = 8'h00;
  localparam logic [7:0] RST_OPERATION = 8'h80;
  // Timing
  localparam int MCLK_NS = 4;
  localparam int UNIT_BASE_NS = 1000;
  localparam logic [6:0] DEV_ADDR_DEF = 7'h2c;
endpackage : ivfr_pkg
`default_nettype wire

// ---- ivfr_link.sv ----
`timescale 1ns/10ps
`default_nettype none
module ivfr_link (
  input wire logic sclk,
  input wire logic linkRst_n,
  input wire logic rst_n,
  input wire logic sdaIn,
  input wire logic [6:0] devAddr,
  input wire logic [15:0] rdWord,
  output logic sdaOut,
  output logic sdaOe,
  output logic byteToggle,
  output logic [7:0] byteData
);
  typedef struct packed {
    logic [3:0] bitCnt;
    logic [1:0] byteIdx;
    logic [7:0] shift;
    logic sel;
    logic rd;
    logic mAck;
  } ivfr_link_t;
  typedef struct packed {
    logic tog;
    logic [7:0] data;
  } ivfr_lbyte_t;
  typedef struct packed {
    logic oe;
    logic out;
  } ivfr_ldrv_t;

  ivfr_link_t s, next_s;
  ivfr_lbyte_t b, next_b;
  ivfr_ldrv_t d, next_d;
  logic [7:0] txByte;
  logic byteEnd;

  assign byteEnd = (s.bitCnt == 4'h7);
  assign txByte = (s.byteIdx == 2'h1) ? rdWord[7:0] :
                  (s.byteIdx == 2'h2) ? rdWord[15:8] : 8'hff;

  always_comb begin
    next_s = s;
    if (s.bitCnt < 4'h8) begin
      next_s.shift = {s.shift[6:0], sdaIn};
      next_s.bitCnt = s.bitCnt + 4'h1;
      if (byteEnd && s.byteIdx == 2'h0) begin
        next_s.sel = (s.shift[6:0] == devAddr);
        next_s.rd = sdaIn;
      end
    end else begin
      next_s.bitCnt = 4'h0;
      // A master nack ends the read stream
      next_s.mAck = (s.byteIdx == 2'h0) ? 1'b1 : (s.mAck && !sdaIn);
      if (s.byteIdx != 2'h3) begin
        next_s.byteIdx = s.byteIdx + 2'h1;
      end
    end
  end

  always_comb begin
    next_b = b;
    if (byteEnd && s.sel && !s.rd && s.byteIdx != 2'h0) begin
      next_b.tog = !b.tog;
      next_b.data = {s.shift[6:0], sdaIn};
    end
  end

  always_comb begin
    next_d.out = 1'b0;
    if (s.bitCnt == 4'h8) begin
      next_d.oe = (s.byteIdx == 2'h0) ? s.sel : (s.sel && !s.rd);
    end else begin
      next_d.oe = s.sel && s.rd && s.mAck && (s.byteIdx != 2'h0) &&
                  !txByte[~s.bitCnt[2:0]];
    end
  end

  always_ff @(posedge sclk or negedge linkRst_n) begin
    if (!linkRst_n) s <= '0;
    else s <= next_s;
  end

  always_ff @(posedge sclk or negedge rst_n) begin
    if (!rst_n) b <= '0;
    else b <= next_b;
  end

  // Drive on the falling edge so data is stable while the clock is high
  always_ff @(negedge sclk or negedge linkRst_n) begin
    if (!linkRst_n) d <= '0;
    else d <= next_d;
  end

  assign sdaOut = d.out;
  assign sdaOe = d.oe;
  assign byteToggle = b.tog;
  assign byteData = b.data;
endmodule : ivfr_link
`default_nettype wire

// ---- ivfr_responder.sv ----
`timescale 1ns/10ps
`default_nettype none
module ivfr_responder (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic faultNow,
  input wire logic [7:0] action,
  input wire logic [23:0] unitLen,
  input wire logic clearReq,
  input wire logic offCmd,
  input wire logic otherShutdown,
  output logic outEn,
  output logic latched
);
  typedef enum logic [2:0] {
    ST_RUN = 3'h0,
    ST_GRACE = 3'h1,
    ST_OFF = 3'h2,
    ST_TRY = 3'h3,
    ST_HOLD = 3'h4
  } ivfr_rstate_t;
  typedef struct packed {
    ivfr_rstate_t state;
    logic [23:0] unitCnt;
    logic [7:0] units;
    logic [2:0] left;
    logic outEn;
  } ivfr_resp_t;

  ivfr_resp_t s, next_s;
  logic [1:0] resp;
  logic [2:0] retry;
  logic [2:0] delay;
  logic tick, expire, load, goDown;

  assign resp = action[ivfr_pkg::ACT_RESP_LO +: 2];
  assign retry = action[ivfr_pkg::ACT_RETRY_LO +: 3];
  assign delay = action[ivfr_pkg::ACT_DELAY_LO +: 3];
  assign tick = (s.unitCnt == 24'h000000);
  assign expire = tick && (s.units == 8'h01);

  always_comb begin
    next_s = s;
    load = 1'b0;
    goDown = 1'b0;
    if (tick) begin
      next_s.unitCnt = unitLen - 24'h000001;
      next_s.units = s.units - 8'h01;
    end else begin
      next_s.unitCnt = s.unitCnt - 24'h000001;
    end
    if (clearReq || offCmd) begin
      next_s.state = ST_RUN;
    end else if (otherShutdown && s.state != ST_RUN) begin
      next_s.state = ST_HOLD;
    end else begin
      unique case (s.state)
        ST_RUN: begin
          if (faultNow) begin
            unique case (resp)
              ivfr_pkg::RESP_IGNORE: ;
              ivfr_pkg::RESP_DELAY: begin
                next_s.state = ST_GRACE;
                load = 1'b1;
              end
              ivfr_pkg::RESP_RETRY: goDown = 1'b1;
              ivfr_pkg::RESP_LATCH: next_s.state = ST_HOLD;
            endcase
          end
        end
        ST_GRACE: begin
          if (!faultNow) next_s.state = ST_RUN;
          else if (expire) goDown = 1'b1;
        end
        ST_OFF: begin
          if (expire) begin
            next_s.state = ST_TRY;
            load = 1'b1;
          end
        end
        ST_TRY: begin
          // Spacing runs from attempt start, so a failure keeps the count
          if (faultNow) begin
            if (retry == ivfr_pkg::RETRY_FOREVER) begin
              next_s.state = ST_OFF;
            end else if (s.left > 3'h1) begin
              next_s.left = s.left - 3'h1;
              next_s.state = ST_OFF;
            end else begin
              next_s.state = ST_HOLD;
            end
          end else if (expire) begin
            next_s.state = ST_RUN;
          end
        end
        ST_HOLD: ;
        default: next_s.state = ST_RUN;
      endcase
    end
    if (goDown) begin
      if (retry == ivfr_pkg::RETRY_NONE) begin
        next_s.state = ST_HOLD;
      end else begin
        next_s.state = ST_OFF;
        next_s.left = retry;
        load = 1'b1;
      end
    end
    if (load) begin
      next_s.unitCnt = unitLen - 24'h000001;
      next_s.units = 8'h01 << delay;
    end
    next_s.outEn = (next_s.state != ST_OFF) && (next_s.state != ST_HOLD);
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) s <= '{state: ST_RUN, outEn: 1'b1, default: '0};
    else s <= next_s;
  end

  assign outEn = s.outEn;
  assign latched = (s.state == ST_HOLD);

  chk_ignore_keeps_on:
  assert property (@(posedge mclk) disable iff (!rst_n)
    s.state == ST_RUN && faultNow && resp == ivfr_pkg::RESP_IGNORE
    && !clearReq && !offCmd |=> s.state == ST_RUN && s.outEn)
    else $error("ignored fault changed output");
  chk_grace_keeps_on:
  assert property (@(posedge mclk) disable iff (!rst_n)
    s.state == ST_RUN && faultNow && resp == ivfr_pkg::RESP_DELAY
    && !clearReq && !offCmd |=> s.state == ST_GRACE && s.outEn
    && s.units == (8'h01 << delay))
    else $error("delayed response not entered");
  chk_disable_now:
  assert property (@(posedge mclk) disable iff (!rst_n)
    s.state == ST_RUN && faultNow && resp == ivfr_pkg::RESP_RETRY
    && !clearReq && !offCmd |=> !s.outEn)
    else $error("output not disabled at once");
  chk_no_retry_hold:
  assert property (@(posedge mclk) disable iff (!rst_n)
    s.state == ST_RUN && faultNow && resp == ivfr_pkg::RESP_RETRY
    && retry == ivfr_pkg::RETRY_NONE && !clearReq && !offCmd
    |=> s.state == ST_HOLD)
    else $error("zero retries did not latch");
  chk_hold_until_clear:
  assert property (@(posedge mclk) disable iff (!rst_n)
    s.state == ST_HOLD && !clearReq && !offCmd |=> s.state == ST_HOLD
    && !s.outEn)
    else $error("latched fault released early");
  chk_last_try_latches:
  assert property (@(posedge mclk) disable iff (!rst_n)
    s.state == ST_TRY && faultNow && s.left == 3'h1
    && retry != ivfr_pkg::RETRY_FOREVER && !clearReq && !offCmd
    && !otherShutdown |=> s.state == ST_HOLD)
    else $error("retries not exhausted to latch");
  chk_forever_retries:
  assert property (@(posedge mclk) disable iff (!rst_n)
    s.state == ST_TRY && faultNow && retry == ivfr_pkg::RETRY_FOREVER
    && !clearReq && !offCmd && !otherShutdown |=> s.state == ST_OFF)
    else $error("endless retry stopped");
  chk_try_spacing:
  assert property (@(posedge mclk) disable iff (!rst_n)
    s.state == ST_OFF && expire && !clearReq && !offCmd && !otherShutdown
    |=> s.state == ST_TRY && s.outEn && s.unitCnt == unitLen - 24'h000001)
    else $error("restart attempt not started on time");
endmodule : ivfr_responder
`default_nettype wire

// ---- ivfr_host.sv ----
`timescale 1ns/10ps
`default_nettype none
module ivfr_host (
  output logic scl,
  output logic sdaDrv,
  input wire logic sda
);
  // Clock line rests high between frames
  initial begin
    scl = 1'b1;
    sdaDrv = 1'b1;
  end

  // Also serves as repeated start
  task automatic start;
    sdaDrv = 1'b1;
    #12 scl = 1'b1;
    #50 sdaDrv = 1'b0;
    #50 scl = 1'b0;
  endtask : start

  task automatic stop;
    #12 sdaDrv = 1'b0;
    #12 scl = 1'b1;
    #50 sdaDrv = 1'b1;
    #150;
  endtask : stop

  task automatic xbit(input logic b, output logic r);
    #12 sdaDrv = b;
    #12 scl = 1'b1;
    #12 r = sda;
    #12 scl = 1'b0;
  endtask : xbit

  // Eight bits msb first, then the acknowledge slot
  task automatic xbyte(input logic [7:0] d, input logic ackIn,
                       output logic [7:0] q, output logic ack);
    for (int i = 7; i >= 0; i--) xbit(d[i], q[i]);
    xbit(ackIn, ack);
  endtask : xbyte
endmodule : ivfr_host
`default_nettype wire

// ---- tb.sv ----
`timescale 1ns/10ps
`default_nettype none
module tb;
  localparam logic [6:0] ADDR = 7'h2c;
  localparam int U = 8 / ivfr_pkg::MCLK_NS;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic ctrlOn = 1'b1;
  logic vinValid = 1'b0;
  logic otherFault = 1'b0;
  logic [15:0] vinSample = 16'h8000;
  logic [15:0] rv;
  logic scl, sdaDrv, sdaOut, sdaOe, outputEnable, ratioRegulationMode;
  logic faultLatched;
  int nErrors = 0;
  int totalChecks = 0;
  wire sda = sdaDrv & (~sdaOe | sdaOut);

  ivfr_host h (.scl(scl), .sdaDrv(sdaDrv), .sda(sda));
  ivfr_top #(.DEV_ADDR(ADDR), .UNIT_NS(8)) DUT (.mclk(mclk), .rst_n(rst_n),
    .sclk(scl), .sclIn(scl), .sdaIn(sda), .ctrlOn(ctrlOn),
    .vinSample(vinSample), .vinValid(vinValid), .otherFault(otherFault),
    .sdaOut(sdaOut), .sdaOe(sdaOe), .outputEnable(outputEnable),
    .ratioRegulationMode(ratioRegulationMode), .faultLatched(faultLatched));

  always #2 mclk = ~mclk;

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", totalChecks, nErrors);
    if (nErrors == 0 && totalChecks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : report_and_stop

  task automatic chk(input string n, input logic [15:0] e,
                     input logic [15:0] g);
    totalChecks++;
    if (g !== e) begin
      nErrors++;
      $display("FAIL %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic ws(ref logic s, input logic v, input int n, input string m);
    for (int i = 0; i < n && s !== v; i++) @(negedge mclk);
    chk(m, {15'h0, v}, {15'h0, s});
    if (s !== v) report_and_stop();
  endtask : ws

  // Negative count means a word read
  task automatic bus(input logic [7:0] c, input logic [15:0] w,
                     input int n, output logic [15:0] r);
    logic [7:0] q;
    logic a;
    r = 16'h0;
    h.start();
    h.xbyte({ADDR, 1'b0}, 1'b1, q, a);
    chk("addr ack", 16'h0, {15'h0, a});
    h.xbyte(c, 1'b1, q, a);
    if (n > 0) h.xbyte(w[7:0], 1'b1, q, a);
    if (n > 1) h.xbyte(w[15:8], 1'b1, q, a);
    if (n < 0) begin
      h.start();
      h.xbyte({ADDR, 1'b1}, 1'b1, q, a);
      h.xbyte(8'hff, 1'b0, r[7:0], a);
      h.xbyte(8'hff, 1'b1, r[15:8], a);
    end
    h.stop();
    repeat (12) @(negedge mclk);
  endtask : bus

  task automatic rst;
    @(negedge mclk);
    rst_n = 1'b0;
    vinValid = 1'b0;
    vinSample = 16'h8000;
    ctrlOn = 1'b1;
    otherFault = 1'b0;
    repeat (2) @(negedge mclk);
    rst_n = 1'b1;
    ws(outputEnable, 1'b1, 20, "power up");
  endtask : rst

  task automatic pv(input logic [15:0] v);
    @(negedge mclk);
    vinSample = v;
    vinValid = 1'b1;
    @(negedge mclk);
    vinValid = 1'b0;
  endtask : pv

  task automatic cnt(input int n, output int r, output int g);
    logic p;
    int last;
    r = 0;
    g = 9999;
    last = -1;
    p = outputEnable;
    for (int i = 0; i < n; i++) begin
      @(negedge mclk);
      if (outputEnable === 1'b1 && p === 1'b0) begin
        r++;
        if (last >= 0 && i - last < g) g = i - last;
        last = i;
      end
      p = outputEnable;
    end
  endtask : cnt

  task automatic t_regs;
    logic [7:0] q;
    logic a;
    rst();
    bus(ivfr_pkg::CMD_OV_WARN, 16'h0, -1, rv);
    chk("ov reset", 16'hffff, rv);
    for (int i = 0; i < 3; i++) begin
      bus(ivfr_pkg::CMD_OV_WARN + 8'(i), 16'ha55a ^ 16'(i), 2, rv);
      bus(ivfr_pkg::CMD_OV_WARN + 8'(i), 16'h0, -1, rv);
      chk("limit", 16'ha55a ^ 16'(i), rv);
    end
    bus(ivfr_pkg::CMD_UV_ACTION, 16'h00b5, 1, rv);
    bus(ivfr_pkg::CMD_UV_ACTION, 16'h0, -1, rv);
    chk("action", 16'h00b5, rv);
    h.start();
    h.xbyte({ADDR ^ 7'h01, 1'b0}, 1'b1, q, a);
    h.stop();
    chk("foreign addr", 16'h1, {15'h0, a});
    chk("sda out", 16'h0, {15'h0, sdaOut});
    $display("test regs done");
  endtask : t_regs

  task automatic t_ratio;
    rst();
    bus(ivfr_pkg::CMD_UV_WARN, 16'h1000, 2, rv);
    pv(16'h0800);
    repeat (8) @(negedge mclk);
    chk("ratio off", 16'h0, {15'h0, ratioRegulationMode});
    bus(ivfr_pkg::CMD_VENDOR_OPT, 16'h0001, 1, rv);
    pv(16'h0800);
    ws(ratioRegulationMode, 1'b1, 8, "ratio on");
    pv(16'h1800);
    ws(ratioRegulationMode, 1'b0, 8, "ratio high");
    $display("test ratio done");
  endtask : t_ratio

  task automatic t_status;
    rst();
    bus(ivfr_pkg::CMD_OV_WARN, 16'h3000, 2, rv);
    pv(16'h4000);
    bus(ivfr_pkg::CMD_STATUS_INPUT, 16'h0, -1, rv);
    chk("status ov", 16'h0020, rv);
    bus(ivfr_pkg::CMD_UV_WARN, 16'h1000, 2, rv);
    bus(ivfr_pkg::CMD_UV_FAULT, 16'h0800, 2, rv);
    pv(16'h0400);
    bus(ivfr_pkg::CMD_STATUS_INPUT, 16'h0, -1, rv);
    chk("status uv", 16'h0038, rv);
    chk("ignore", 16'h1, {15'h0, outputEnable});
    $display("test status done");
  endtask : t_status

  task automatic t_latch;
    rst();
    bus(ivfr_pkg::CMD_UV_FAULT, 16'h0800, 2, rv);
    bus(ivfr_pkg::CMD_UV_ACTION, 16'h0080, 1, rv);
    pv(16'h0400);
    ws(outputEnable, 1'b0, 3, "disable now");
    ws(faultLatched, 1'b1, 4, "no retry");
    pv(16'h1000);
    repeat (200) @(negedge mclk);
    chk("stays off", 16'h0, {15'h0, outputEnable});
    bus(ivfr_pkg::CMD_CLEAR_FAULTS, 16'h0, 0, rv);
    ws(outputEnable, 1'b1, 20, "cleared");
    bus(ivfr_pkg::CMD_UV_ACTION, 16'h00c0, 1, rv);
    pv(16'h0400);
    ws(outputEnable, 1'b0, 3, "latch off");
    pv(16'h1000);
    repeat (50) @(negedge mclk);
    chk("held off", 16'h0, {15'h0, outputEnable});
    ctrlOn = 1'b0;
    repeat (10) @(negedge mclk);
    ctrlOn = 1'b1;
    ws(outputEnable, 1'b1, 20, "ctrl cycle");
    $display("test latch done");
  endtask : t_latch

  task automatic t_delay;
    int i;
    rst();
    bus(ivfr_pkg::CMD_DELAY_UNIT, 16'h0001, 2, rv);
    bus(ivfr_pkg::CMD_UV_FAULT, 16'h0800, 2, rv);
    bus(ivfr_pkg::CMD_UV_ACTION, 16'h0047, 1, rv);
    pv(16'h0400);
    for (i = 0; i < 2000 && outputEnable === 1'b1; i++) @(negedge mclk);
    chk("run delay", 16'h1,
        {15'h0, i >= 256*U - 12 && i <= 256*U + 12});
    if (i >= 2000) report_and_stop();
    ws(faultLatched, 1'b1, 4, "after delay");
    $display("test delay done");
  endtask : t_delay

  task automatic t_retry;
    int r, g;
    for (int k = 1; k < 8; k++) begin
      rst();
      bus(ivfr_pkg::CMD_UV_FAULT, 16'h0800, 2, rv);
      bus(ivfr_pkg::CMD_UV_ACTION, {8'h0, 2'h2, 3'(k), 3'h2}, 1, rv);
      @(negedge mclk);
      vinSample = 16'h0400;
      vinValid = 1'b1;
      cnt(400, r, g);
      if (k < 7) chk("restarts", 16'(k), 16'(r));
      else chk("endless", 16'h1, {15'h0, r > 8});
      chk("spacing", 16'h1, {15'h0, k == 1 || g == 4 * U});
      chk("latched", {15'h0, k < 7}, {15'h0, faultLatched});
    end
    otherFault = 1'b1;
    ws(faultLatched, 1'b1, 10, "other fault");
    cnt(200, r, g);
    chk("stopped", 16'h0, 16'(r));
    $display("test retry done");
  endtask : t_retry

  initial begin
    t_regs();
    t_ratio();
    t_status();
    t_latch();
    t_delay();
    t_retry();
    report_and_stop();
  end
endmodule : tb
`default_nettype wire
